// >>> core/gis_map.vh
// Constants of the gripper I/O sequencer: register offsets, field positions,
// reset values and timing counts.
// Assumes a 25 MHz ref_clk and a Wishbone byte address of 8 bits.
`ifndef GIS_MAP_VH
`define GIS_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define GIS_ADR_CTRL      8'h00
`define GIS_ADR_HAND_CFG  8'h04
`define GIS_ADR_ENG_DEF   8'h08
`define GIS_ADR_ENG_MS    8'h0c
`define GIS_ADR_REL_DEF   8'h10
`define GIS_ADR_REL_MS    8'h14
`define GIS_ADR_STATUS    8'h18
`define GIS_ADR_IRQ_STAT  8'h1c
`define GIS_ADR_IRQ_CLR   8'h20
`define GIS_ADR_IRQ_EN    8'h24

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define GIS_CTRL_ENGAGE   0
`define GIS_CTRL_RELEASE  1
`define GIS_CFG_SUCTION   0
`define GIS_CFG_SCREW     1
`define GIS_CFG_TWO_OUT   2
`define GIS_CFG_NIN_LO    3
`define GIS_CFG_NIN_HI    4
`define GIS_DEF_OUT_A     0
`define GIS_DEF_OUT_B     1
`define GIS_DEF_POL_A     4
`define GIS_DEF_POL_B     5
`define GIS_DEF_WAIT_EN   8
`define GIS_IRQ_DONE      0
`define GIS_IRQ_TMO       1

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define GIS_RST_CFG       5'h00
`define GIS_RST_DEF       9'h000
`define GIS_RST_MS        14'h000a
`define GIS_RST_IRQ       2'h0

////////////////////////////////////////////////////////////////////////////////
// Timing
`define GIS_MS_MIN        14'd10
`define GIS_MS_MAX        14'd10000
`define GIS_CLK_PERIOD_NS 40
`define GIS_TICK_NS       1000000
`define GIS_TICK_CYCLES   (`GIS_TICK_NS / `GIS_CLK_PERIOD_NS)

`endif

// >>> core/gis_tick.v
// Millisecond tick generator for the gripper I/O sequencer.
// Assumes restart is a same-clock pulse; tick follows MS_CYCLES cycles later.
`timescale 1ns/1ps

module gis_tick #(
  parameter CNT_W     = 16,
  parameter MS_CYCLES = 25000
) (
  ref_clk,
  rst_n,
  restart,
  tick
);
  input  wire ref_clk;
  input  wire rst_n;
  input  wire restart;
  output reg  tick;

  localparam integer     LAST_I = MS_CYCLES - 1;
  localparam [CNT_W-1:0] LAST   = LAST_I[CNT_W-1:0];

  reg [CNT_W-1:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Restart aligns the tick to command start, so each count is whole
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {CNT_W{1'b0}};
      tick  <= 1'b0;
    end else if (restart) begin
      cnt_q <= {CNT_W{1'b0}};
      tick  <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q <= {CNT_W{1'b0}};
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      tick  <= 1'b0;
    end
  end
endmodule // gis_tick

// >>> core/gis_seq.v
// Gripper I/O sequencer: engage and release command engine with a
// Wishbone classic register slave and one level interrupt.
// Assumes sense inputs come from pins (synchronised here) and one 25 MHz clock.
`timescale 1ns/1ps
`include "gis_map.vh"

module gis_seq #(
  parameter MS_CYCLES = `GIS_TICK_CYCLES
) (
  ref_clk,
  rst_n,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_adr_i,
  wb_dat_i,
  wb_sel_i,
  wb_dat_o,
  wb_ack_o,
  sense_in_a,
  sense_in_b,
  act_out_a,
  act_out_b,
  busy,
  irq
);
  input  wire        ref_clk;
  input  wire        rst_n;
  input  wire        wb_cyc_i;
  input  wire        wb_stb_i;
  input  wire        wb_we_i;
  input  wire [7:0]  wb_adr_i;
  input  wire [31:0] wb_dat_i;
  input  wire [3:0]  wb_sel_i;
  output reg  [31:0] wb_dat_o;
  output reg         wb_ack_o;
  input  wire        sense_in_a;
  input  wire        sense_in_b;
  output reg         act_out_a;
  output reg         act_out_b;
  output reg         busy;
  output reg         irq;

  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg  [4:0]  cfg_q;
  reg  [8:0]  eng_def_q;
  reg  [8:0]  rel_def_q;
  reg  [13:0] eng_ms_q;
  reg  [13:0] rel_ms_q;
  reg  [1:0]  irq_en_q;
  reg  [1:0]  irq_stat_q;
  reg  [1:0]  irq_stat_d;
  reg         state_q;
  reg         rel_run_q;
  reg         imm_q;
  reg         brk_q;
  reg  [13:0] lim_q;
  reg  [13:0] ms_cnt_q;
  reg         tmo_q;
  reg         res_eng_q;
  reg         res_rel_q;
  reg  [1:0]  sync1_q;
  reg  [1:0]  sync2_q;
  reg  [1:0]  ok;
  reg  [31:0] rd_d;
  wire        acc;
  wire        wr;
  wire        start_eng;
  wire        start_rel;
  wire        start;
  wire [8:0]  cur_def;
  wire [13:0] cur_ms;
  wire [1:0]  nin;
  wire        has_in;
  wire        suction;
  wire        two_out;
  wire        screw;
  wire        match;
  wire        run_pol_a;
  wire        run_pol_b;
  wire        reached;
  wire        finish;
  wire        timed_out;
  wire        tick;
  wire [1:0]  pins;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode; one access answered per ack, ack drops the cycle after
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr  = acc & wb_we_i;

  assign suction = cfg_q[`GIS_CFG_SUCTION];
  assign screw   = cfg_q[`GIS_CFG_SCREW];
  assign two_out = cfg_q[`GIS_CFG_TWO_OUT];
  assign nin     = cfg_q[`GIS_CFG_NIN_HI:`GIS_CFG_NIN_LO];
  assign has_in  = (nin != 2'd0) & ~screw;

  // Commands while busy are ignored; engage wins if both bits are written
  assign start_eng = wr & (wb_adr_i == `GIS_ADR_CTRL) & wb_sel_i[0] & ~busy
                     & wb_dat_i[`GIS_CTRL_ENGAGE];
  assign start_rel = wr & (wb_adr_i == `GIS_ADR_CTRL) & wb_sel_i[0] & ~busy
                     & wb_dat_i[`GIS_CTRL_RELEASE] & ~wb_dat_i[`GIS_CTRL_ENGAGE];
  assign start     = start_eng | start_rel;
  assign cur_def   = start_rel ? rel_def_q : eng_def_q;
  assign cur_ms    = start_rel ? rel_ms_q : eng_ms_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers on the sense pins
  assign pins = {sense_in_b, sense_in_a};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pins[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Success compare of mapped inputs against the running command polarity
  assign run_pol_a = rel_run_q ? rel_def_q[`GIS_DEF_POL_A] : eng_def_q[`GIS_DEF_POL_A];
  assign run_pol_b = rel_run_q ? rel_def_q[`GIS_DEF_POL_B] : eng_def_q[`GIS_DEF_POL_B];

  // Unmapped inputs count as satisfied, so no sensor means true
  always @* begin
    ok[0] = (nin == 2'd0) | (sync2_q[0] == run_pol_a);
    ok[1] = (nin != 2'd2) | (sync2_q[1] == run_pol_b);
  end

  assign match = &ok;

  ////////////////////////////////////////////////////////////////////////////////
  // Completion terms
  assign reached   = (ms_cnt_q == lim_q);
  assign timed_out = ~imm_q & has_in & ~match & reached;
  assign finish    = (state_q == ST_WAIT) &
                     (imm_q | (has_in & match) | reached);

  gis_tick #(
    .CNT_W     (16),
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .restart (start),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clamp of a written duration into the legal millisecond range
  function [13:0] clamp_ms;
    input [15:0] v;
    begin
      if (v < {2'b00, `GIS_MS_MIN})
        clamp_ms = `GIS_MS_MIN;
      else if (v > {2'b00, `GIS_MS_MAX})
        clamp_ms = `GIS_MS_MAX;
      else
        clamp_ms = v[13:0];
    end
  endfunction

  // Byte-lane merge; low two lanes hold every writable field
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] dat;
    input [1:0]  sel;
    begin
      merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers; held off while a command runs to keep it coherent
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q     <= `GIS_RST_CFG;
      eng_def_q <= `GIS_RST_DEF;
      rel_def_q <= `GIS_RST_DEF;
      eng_ms_q  <= `GIS_RST_MS;
      rel_ms_q  <= `GIS_RST_MS;
      irq_en_q  <= `GIS_RST_IRQ;
    end else if (wr & ~busy) begin
      case (wb_adr_i)
        `GIS_ADR_HAND_CFG: begin
          if (wb_sel_i[0])
            cfg_q <= wb_dat_i[4:0];
        end
        `GIS_ADR_ENG_DEF: begin
          eng_def_q <= {wb_sel_i[1] ? wb_dat_i[8] : eng_def_q[8], 2'b00,
                        wb_sel_i[0] ? {wb_dat_i[5:4], 2'b00, wb_dat_i[1:0]} : eng_def_q[5:0]};
        end
        `GIS_ADR_REL_DEF: begin
          rel_def_q <= {wb_sel_i[1] ? wb_dat_i[8] : rel_def_q[8], 2'b00,
                        wb_sel_i[0] ? {wb_dat_i[5:4], 2'b00, wb_dat_i[1:0]} : rel_def_q[5:0]};
        end
        `GIS_ADR_ENG_MS: begin
          eng_ms_q <= clamp_ms(merge16({2'b00, eng_ms_q}, wb_dat_i[15:0],
                                       wb_sel_i[1:0]));
        end
        `GIS_ADR_REL_MS: begin
          rel_ms_q <= clamp_ms(merge16({2'b00, rel_ms_q}, wb_dat_i[15:0],
                                       wb_sel_i[1:0]));
        end
        `GIS_ADR_IRQ_EN: begin
          if (wb_sel_i[0])
            irq_en_q <= wb_dat_i[1:0];
        end
        default: begin
          irq_en_q <= irq_en_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      busy      <= 1'b0;
      tmo_q     <= 1'b0;
      act_out_a <= 1'b0;
      act_out_b <= 1'b0;
      brk_q     <= 1'b0;
      rel_run_q <= 1'b0;
      imm_q     <= 1'b0;
      lim_q     <= `GIS_RST_MS;
      ms_cnt_q  <= 14'd0;
      res_eng_q <= 1'b0;
      res_rel_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q   <= ST_WAIT;
            busy      <= 1'b1;
            tmo_q     <= 1'b0;
            rel_run_q <= start_rel;
            lim_q     <= cur_ms;
            ms_cnt_q  <= 14'd0;
            // Screwdriver or option off finishes the cycle after apply
            imm_q     <= screw | ~cur_def[`GIS_DEF_WAIT_EN];
            act_out_a <= cur_def[`GIS_DEF_OUT_A];
            if (two_out & suction & ~screw) begin
              act_out_b <= start_rel;
              brk_q     <= start_rel;
            end else if (two_out) begin
              act_out_b <= cur_def[`GIS_DEF_OUT_B];
              brk_q     <= 1'b0;
            end else begin
              act_out_b <= 1'b0;
              brk_q     <= 1'b0;
            end
          end else if (brk_q & has_in & ~sync2_q[0]) begin
            act_out_b <= 1'b0;
            brk_q     <= 1'b0;
          end
        end
        ST_WAIT: begin
          if (tick & ~reached)
            ms_cnt_q <= ms_cnt_q + 14'd1;
          if (brk_q & ((has_in & ~sync2_q[0]) | (~has_in & finish))) begin
            act_out_b <= 1'b0;
            brk_q     <= 1'b0;
          end
          if (finish) begin
            state_q <= ST_IDLE;
            busy    <= 1'b0;
            tmo_q   <= timed_out;
            if (rel_run_q)
              res_rel_q <= match;
            else
              res_eng_q <= match;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy    <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky interrupt status; a new event beats a clear in the same cycle
  always @* begin
    irq_stat_d = irq_stat_q;
    if (wr & (wb_adr_i == `GIS_ADR_IRQ_CLR) & wb_sel_i[0])
      irq_stat_d = irq_stat_d & ~wb_dat_i[1:0];
    if (finish)
      irq_stat_d[`GIS_IRQ_DONE] = 1'b1;
    if (finish & timed_out)
      irq_stat_d[`GIS_IRQ_TMO] = 1'b1;
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= `GIS_RST_IRQ;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq        <= |(irq_stat_d & irq_en_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux; write-only and unmapped words read as zero
  always @* begin
    rd_d = 32'h0000_0000;
    case (wb_adr_i)
      `GIS_ADR_HAND_CFG: rd_d = {27'h0, cfg_q};
      `GIS_ADR_ENG_DEF:  rd_d = {23'h0, eng_def_q};
      `GIS_ADR_ENG_MS:   rd_d = {18'h0, eng_ms_q};
      `GIS_ADR_REL_DEF:  rd_d = {23'h0, rel_def_q};
      `GIS_ADR_REL_MS:   rd_d = {18'h0, rel_ms_q};
      `GIS_ADR_STATUS:   rd_d = {24'h0, act_out_b, act_out_a, sync2_q,
                                 res_rel_q, res_eng_q, tmo_q, busy};
      `GIS_ADR_IRQ_STAT: rd_d = {30'h0, irq_stat_q};
      `GIS_ADR_IRQ_EN:   rd_d = {30'h0, irq_en_q};
      default:           rd_d = 32'h0000_0000;
    endcase
  end

  // Registered answer: ack one cycle after the request, for every address
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= (acc & ~wb_we_i) ? rd_d : 32'h0000_0000;
    end
  end
endmodule // gis_seq

// >>> dv/gis_monitor.sv
// Port-level checker for the gripper I/O sequencer.
// Assumes it is bound into gis_seq with the same MS_CYCLES.
`timescale 1ns/1ps
`include "gis_map.vh"
module gis_monitor #(
  parameter MS_CYCLES = 25000
) (
  input wire        ref_clk,
  input wire        rst_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        sense_in_a,
  input wire        sense_in_b,
  input wire        act_out_a,
  input wire        act_out_b,
  input wire        busy,
  input wire        irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  localparam int unsigned BUSY_MAX = 10000 * MS_CYCLES + 4;
  int unsigned busy_cnt_q;
  wire         take_ctrl;
  assign take_ctrl = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] &&
                     wb_adr_i == `GIS_ADR_CTRL;
  //////////////////////////////////////////////////////////////////////////////
  // Busy spell length; a stuck engine shows as a runaway count
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n) busy_cnt_q <= 0;
    else busy_cnt_q <= busy ? busy_cnt_q + 1 : 0;
  //////////////////////////////////////////////////////////////////////////////
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_RST_OUT: assert property ($rose(rst_n) |-> !busy && !act_out_a && !act_out_b && !irq)
    else $error("outputs not idle after reset");
  AST_CMD_START: assert property (take_ctrl && !busy && wb_dat_i[1:0] != 2'h0 |=> busy)
    else $error("command not started");
  AST_CMD_REFUSE: assert property (take_ctrl && busy |=> $stable(act_out_a))
    else $error("command accepted while busy");
  AST_OUT_CAUSE: assert property ($changed(act_out_a) |-> wb_ack_o && $past(take_ctrl))
    else $error("grip output moved without command");
  AST_BRK_FALL: assert property ($fell(act_out_b) |-> wb_ack_o || !busy ||
    $past(!sense_in_a, 2) || $past(!sense_in_a, 3))
    else $error("break output dropped without cause");
  AST_BUSY_BOUND: assert property (busy_cnt_q <= BUSY_MAX)
    else $error("wait longer than largest duration");
endmodule // gis_monitor

bind gis_seq gis_monitor #(.MS_CYCLES(MS_CYCLES)) gis_monitor_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sense_in_a(sense_in_a),
  .sense_in_b(sense_in_b), .act_out_a(act_out_a), .act_out_b(act_out_b),
  .busy(busy), .irq(irq));

// >>> dv/gis_hand_model.sv
// Behavioural hand: grip sensor follows the grip output, open sensor its inverse.
// Assumes the bench picks the settle latency and may freeze the hand.
`timescale 1ns/1ps
module gis_hand_model (
  input wire        ref_clk,
  input wire        act_out_a,
  input wire        respond,
  input wire [3:0]  lat,
  output logic      sense_in_a,
  output logic      sense_in_b
);
  logic [3:0] cnt_q;
  initial begin
    sense_in_a = 1'b0;
    sense_in_b = 1'b1;
    cnt_q = 4'h0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Sensors settle lat+1 cycles after a move; a frozen hand never gets there
  always @(posedge ref_clk) begin
    if (!respond || (sense_in_a == act_out_a && sense_in_b == !act_out_a)) cnt_q <= 4'h0;
    else if (cnt_q >= lat) begin
      sense_in_a <= act_out_a;
      sense_in_b <= !act_out_a;
    end else cnt_q <= cnt_q + 4'h1;
  end
endmodule // gis_hand_model

// >>> dv/testbench.sv
// Self-checking bench for gis_seq with a behavioural hand.
// Assumes MS_CYCLES shortened to 10 so a millisecond is 10 clocks.
`timescale 1ns/1ps
`include "gis_map.vh"
module testbench;
  localparam int MSC = 10;
  logic ref_clk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, rd;
  logic [3:0]  wb_sel_i = 4'hf, lat = 4'h2;
  logic respond = 1'b1, sense_in_a, sense_in_b, act_out_a, act_out_b, busy, irq, wb_ack_o;
  logic [31:0] wb_dat_o;
  int checked = 0, miscompares = 0, n, ms;
  bit eng;
  gis_seq #(.MS_CYCLES(MSC)) gis_seq_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sense_in_a(sense_in_a), .sense_in_b(sense_in_b), .act_out_a(act_out_a),
    .act_out_b(act_out_b), .busy(busy), .irq(irq));
  gis_hand_model gis_hand_model_inst (.ref_clk(ref_clk), .act_out_a(act_out_a),
    .respond(respond), .lat(lat), .sense_in_a(sense_in_a), .sense_in_b(sense_in_b));
  initial forever #20 ref_clk = !ref_clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Classic single cycle; request held until ack is sampled
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (wb_ack_o !== 1'b1) miscompares++;
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask
  task automatic idle;
    n = 0;
    while (busy === 1'b1 && n < 200000) begin
      @(posedge ref_clk);
      n++;
    end
    if (busy === 1'b1) miscompares++;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic cmd(input logic [1:0] c);
    bus(1'b1, `GIS_ADR_CTRL, {30'h0, c});
    idle();
  endtask
  // Wait of ms whole ticks, a few cycles of slack for sync and launch
  function automatic logic [31:0] in_win(int cyc, int t);
    return {31'h0, cyc >= t * MSC - 4 && cyc <= t * MSC + 6};
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 20000);
    miscompares++;
    stop_test();
  end
  initial begin
    void'($urandom(77996));
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rchk(`GIS_ADR_HAND_CFG, 32'hffffffff, 32'h0);
    rchk(`GIS_ADR_ENG_MS, 32'hffffffff, 32'ha);
    rchk(`GIS_ADR_STATUS, 32'hcf, 32'h0);
    rchk(8'h40, 32'hffffffff, 32'h0);
    bus(1'b1, `GIS_ADR_ENG_MS, 32'h5);
    rchk(`GIS_ADR_ENG_MS, 32'h3fff, 32'ha);
    bus(1'b1, `GIS_ADR_REL_MS, 32'h2ee0);
    rchk(`GIS_ADR_REL_MS, 32'h3fff, 32'h2710);
    ms = 10 + $urandom % 9991;
    bus(1'b1, `GIS_ADR_ENG_MS, ms);
    rchk(`GIS_ADR_ENG_MS, 32'h3fff, ms);
    bus(1'b1, `GIS_ADR_ENG_MS, 32'ha);
    bus(1'b1, `GIS_ADR_REL_MS, 32'ha);
    bus(1'b1, `GIS_ADR_HAND_CFG, 32'h14);
    bus(1'b1, `GIS_ADR_ENG_DEF, 32'h111);
    bus(1'b1, `GIS_ADR_REL_DEF, 32'h122);
    bus(1'b1, `GIS_ADR_IRQ_EN, 32'h3);
    rchk(`GIS_ADR_REL_DEF, 32'hffffffff, 32'h122);
    // Random engage and release with random sensor lag
    for (int i = 0; i < 6; i++) begin
      eng = 1'($urandom % 2);
      lat <= 4'($urandom % 16);
      cmd(eng ? 2'h1 : 2'h2);
      check({act_out_a, act_out_b}, {eng, !eng});
      check(in_win(n, 1) | (n < 30), 32'h1);
      rchk(`GIS_ADR_STATUS, eng ? 32'h6 : 32'ha, eng ? 32'h4 : 32'h8);
      check(irq, 32'h1);
      bus(1'b1, `GIS_ADR_IRQ_CLR, 32'h3);
      @(posedge ref_clk);
      check(irq, 32'h0);
    end
    // Second command while busy is dropped; start engaged so release must move
    lat <= 4'hf;
    cmd(2'h1);
    bus(1'b1, `GIS_ADR_CTRL, 32'h2);
    bus(1'b1, `GIS_ADR_CTRL, 32'h1);
    check(act_out_a, 32'h0);
    idle();
    // Frozen hand: engage times out after 10 ms
    respond <= 1'b0;
    cmd(2'h1);
    check(in_win(n, 10), 32'h1);
    rchk(`GIS_ADR_STATUS, 32'h6, 32'h2);
    rchk(`GIS_ADR_IRQ_STAT, 32'h3, 32'h3);
    respond <= 1'b1;
    bus(1'b1, `GIS_ADR_IRQ_CLR, 32'h3);
    bus(1'b1, `GIS_ADR_IRQ_EN, 32'h0);
    cmd(2'h1);
    check(irq, 32'h0);
    rchk(`GIS_ADR_STATUS, 32'h2, 32'h0);
    // No inputs: fixed delay, then immediate, then screwdriver
    bus(1'b1, `GIS_ADR_HAND_CFG, 32'h04);
    bus(1'b1, `GIS_ADR_ENG_MS, 32'hc);
    cmd(2'h1);
    check(in_win(n, 12), 32'h1);
    bus(1'b1, `GIS_ADR_ENG_DEF, 32'h011);
    cmd(2'h1);
    check(n <= 2, 32'h1);
    bus(1'b1, `GIS_ADR_ENG_DEF, 32'h111);
    bus(1'b1, `GIS_ADR_HAND_CFG, 32'h16);
    cmd(2'h1);
    check(n <= 2, 32'h1);
    // Suction, two outputs, one input: break pulse on release
    bus(1'b1, `GIS_ADR_HAND_CFG, 32'h0d);
    bus(1'b1, `GIS_ADR_REL_DEF, 32'h100);
    bus(1'b1, `GIS_ADR_REL_MS, 32'h64);
    cmd(2'h1);
    check(act_out_b, 32'h0);
    bus(1'b1, `GIS_ADR_CTRL, 32'h2);
    check({act_out_a, act_out_b}, 32'h1);
    idle();
    check(act_out_b, 32'h0);
    check(n < 40, 32'h1);
    // Reset in mid-command drops the hand and clears the engine
    bus(1'b1, `GIS_ADR_CTRL, 32'h1);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    check({busy, act_out_a, act_out_b, irq}, 32'h0);
    rst_n <= 1'b1;
    rchk(`GIS_ADR_STATUS, 32'hcf, 32'h0);
    stop_test();
  end
endmodule // testbench
